// ==== rtl/modbus_coil_read_responder.sv ====
// Overview of operation
// [RULE1] act only on address matching own address
// [RULE2] function 02 hex reports input states
// [RULE3] function 01 hex reports output states
// [RULE4] master sends start, count, msb first
// [RULE5] checksum sent low byte first
// [RULE6] reply repeats request slave address
// [RULE7] reply echoes request function code
// [RULE8] reply carries count of state bytes
// [RULE9] state bit: open 0, closed 1
// [RULE10] first byte inputs one..eight, lsb first
// [RULE11] later groups of eight fill next byte
// [RULE12] output reads packed the same way
// [RULE13] input index n maps to input n+1
// [RULE14] output index zero selects output one
// [RULE15] any subset range reported exactly
// [RULE16] crc-16 a001/ffff; bad frames dropped silently
// [RULE17] unused bits of last byte are zero
`default_nettype none
module modbus_coil_read_responder
  import coil_read_pkg::*;
#(
  parameter int POINTS = coil_read_pkg::POINT_COUNT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // link to master
  coil_link_if.responder link,
  // user side
  input wire logic [7:0] own_addr,
  input wire logic [POINTS-1:0] input_states,
  input wire logic [POINTS-1:0] output_states,
  output logic frame_dropped
);
  import coil_read_pkg::*;

  typedef enum {RECV, CHECK, SEND} state_type;
  state_type state_ff, nxt_state;

  logic [7:0] req_ff [REQ_LEN];
  logic [3:0] rx_cnt_ff;
  logic [15:0] rx_crc_ff;
  logic [15:0] tx_crc_ff;
  logic [7:0] tx_idx_ff;
  logic [7:0] tx_len_ff;
  logic [POINTS-1:0] snap_ff;
  logic dropped_ff;

  // two-entry reply buffer
  logic [7:0] buf_ff [2];
  logic [1:0] buf_cnt_ff;
  logic buf_rd_ff;
  logic buf_wr_ff;

  // decode of the held request
  wire [7:0] r_addr = req_ff[0];
  wire [7:0] r_func = req_ff[1];
  wire [15:0] r_start = {req_ff[2], req_ff[3]}; // msb first [RULE4]
  wire [15:0] r_qty = {req_ff[4], req_ff[5]};
  wire [15:0] r_crc = {req_ff[7], req_ff[6]}; // low byte first [RULE5]
  wire addr_ok = (r_addr == own_addr) && (own_addr >= ADDR_MIN)
    && (own_addr <= ADDR_MAX); // [RULE1]
  wire func_ok = (r_func == FUNC_READ_INPUTS) || (r_func == FUNC_READ_OUTPUTS);
  wire [16:0] r_end = {1'b0, r_start} + {1'b0, r_qty};
  wire range_ok = (r_qty != 16'h0000) && (r_end <= 17'(POINTS)); // [RULE15]
  wire crc_ok = (rx_crc_ff == r_crc); // [RULE16]
  wire frame_ok = addr_ok && func_ok && range_ok && crc_ok;
  wire [7:0] byte_cnt = 8'((r_qty + 16'd7) >> 3); // [RULE8]

  // source selection and shift of the requested window
  wire [POINTS-1:0] src = (r_func == FUNC_READ_INPUTS) ? input_states  // [RULE2]
    : output_states; // [RULE3]
  wire [POINTS-1:0] shifted = snap_ff >> r_start; // index n is point n+1 [RULE13] [RULE14]
  wire [7:0] data_idx = tx_idx_ff - RSP_DATA_POS;
  wire [POINTS+7:0] padded = {8'h00, shifted};
  wire [7:0] raw_byte = padded[data_idx*8 +: 8]; // [RULE10] [RULE11] [RULE12]
  wire [15:0] bits_left = r_qty - {5'h00, data_idx, 3'b000};
  wire [7:0] keep_mask = (bits_left >= 16'd8) ? 8'hff
    : 8'((9'h001 << bits_left[2:0]) - 9'h001);
  wire [7:0] state_byte = raw_byte & keep_mask; // closed reads 1 [RULE9] [RULE17]

  // positions of the two checksum bytes in the reply
  wire [7:0] crc_lo_pos = tx_len_ff - 8'd2;
  wire [7:0] crc_hi_pos = tx_len_ff - 8'd1;

  // byte to emit at tx_idx_ff
  logic [7:0] tx_byte;
  always_comb begin
    if (tx_idx_ff == RSP_ADDR_POS) begin
      tx_byte = r_addr; // [RULE6]
    end else if (tx_idx_ff == RSP_FUNC_POS) begin
      tx_byte = r_func; // [RULE7]
    end else if (tx_idx_ff == RSP_COUNT_POS) begin
      tx_byte = byte_cnt; // [RULE8]
    end else if (tx_idx_ff == crc_lo_pos) begin
      tx_byte = tx_crc_ff[7:0]; // checksum_low_byte [RULE5]
    end else if (tx_idx_ff == crc_hi_pos) begin
      tx_byte = tx_crc_ff[15:8]; // checksum_high_byte [RULE5]
    end else begin
      tx_byte = state_byte;
    end
  end

  wire buf_full = (buf_cnt_ff == 2'd2);
  wire push = (state_ff == SEND) && !buf_full;
  wire pop = link.rsp_valid && link.rsp_ready;
  wire crc_payload = tx_idx_ff < crc_lo_pos;
  wire tx_done = push && (tx_idx_ff == crc_hi_pos);
  wire rx_take = link.req_valid && link.req_ready;
  wire rx_last = (rx_cnt_ff == 4'(REQ_LEN - 1)); // eighth request byte

  assign link.req_ready = (state_ff == RECV);
  assign link.rsp_valid = (buf_cnt_ff != 2'd0);
  assign link.rsp_data = buf_ff[buf_rd_ff];
  assign frame_dropped = dropped_ff;

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RECV: begin
        if (rx_take && rx_last) begin
          nxt_state = CHECK;
        end
      end
      CHECK: begin
        nxt_state = frame_ok ? SEND : RECV; // [RULE16]
      end
      SEND: begin
        if (tx_done) begin
          nxt_state = RECV;
        end
      end
      default: begin
        nxt_state = RECV;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= RECV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // request capture and running crc over the first six bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt_ff <= 4'h0;
      rx_crc_ff <= CRC_INIT;
      for (int i = 0; i < REQ_LEN; i++) begin
        req_ff[i] <= RESET_BYTE;
      end
    end else if (rx_take) begin
      req_ff[rx_cnt_ff[2:0]] <= link.req_data;
      rx_cnt_ff <= rx_last ? 4'h0 : rx_cnt_ff + 4'h1;
      if (rx_cnt_ff == 4'h0) begin
        rx_crc_ff <= crc_byte(CRC_INIT, link.req_data);
      end else if (rx_cnt_ff < 4'(REQ_LEN - 2)) begin
        rx_crc_ff <= crc_byte(rx_crc_ff, link.req_data);
      end
    end
  end

  // reply sequencing and crc of the reply
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_idx_ff <= 8'h00;
      tx_len_ff <= 8'h00;
      tx_crc_ff <= CRC_INIT;
      snap_ff <= '0;
      dropped_ff <= 1'b0;
    end else if (state_ff == CHECK) begin
      tx_idx_ff <= 8'h00;
      tx_len_ff <= byte_cnt + RSP_FRAME_EXTRA;
      tx_crc_ff <= CRC_INIT;
      snap_ff <= src;
      dropped_ff <= !frame_ok;
    end else begin
      dropped_ff <= 1'b0;
      if (push) begin
        tx_idx_ff <= tx_idx_ff + 8'd1;
        if (crc_payload) tx_crc_ff <= crc_byte(tx_crc_ff, tx_byte); // [RULE16]
      end
    end
  end

  // buffer so a stalled master loses no byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_ff[0] <= RESET_BYTE;
      buf_ff[1] <= RESET_BYTE;
      buf_cnt_ff <= 2'd0;
      buf_rd_ff <= 1'b0;
      buf_wr_ff <= 1'b0;
    end else begin
      if (push) begin
        buf_ff[buf_wr_ff] <= tx_byte;
        buf_wr_ff <= !buf_wr_ff;
      end
      if (pop) begin
        buf_rd_ff <= !buf_rd_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + 2'(push) - 2'(pop);
    end
  end
endmodule // modbus_coil_read_responder
`default_nettype wire

// ==== rtl/coil_read_pkg.sv ====
`default_nettype none
package coil_read_pkg;
  localparam logic [7:0] FUNC_READ_OUTPUTS = 8'h01;
  localparam logic [7:0] FUNC_READ_INPUTS = 8'h02;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int REQ_LEN = 8;
  localparam int POINT_COUNT = 16;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // reply byte positions: address, function and count lead the state bytes
  localparam logic [7:0] RSP_ADDR_POS = 8'd0;
  localparam logic [7:0] RSP_FUNC_POS = 8'd1;
  localparam logic [7:0] RSP_COUNT_POS = 8'd2;
  localparam logic [7:0] RSP_DATA_POS = 8'd3;
  localparam logic [7:0] RSP_FRAME_EXTRA = 8'd5; // header plus two checksum bytes
  // request byte positions of the appended checksum
  localparam logic [3:0] REQ_CRC_LO_POS = 4'd6;
  localparam logic [3:0] REQ_CRC_HI_POS = 4'd7;

  // one byte folded into the running crc
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/coil_link_if.sv ====
`default_nettype none
interface coil_link_if;
  logic [7:0] req_data;
  logic req_valid;
  logic req_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic rsp_ready;
  modport responder (input req_data, input req_valid, output req_ready,
    output rsp_data, output rsp_valid, input rsp_ready);
  modport master (output req_data, output req_valid, input req_ready,
    input rsp_data, input rsp_valid, output rsp_ready);
endinterface
`default_nettype wire

// ==== rtl/modbus_coil_read_master.sv ====
`default_nettype none
module modbus_coil_read_master
  import coil_read_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // link to responder
  coil_link_if.master link,
  // user request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_func,
  input wire logic [15:0] cmd_start,
  input wire logic [15:0] cmd_qty,
  // reply bytes as received
  output logic [7:0] rsp_byte,
  output logic rsp_byte_valid,
  input wire logic rsp_byte_ready
);
  import coil_read_pkg::*;

  logic [7:0] frame_ff [REQ_LEN];
  logic [3:0] idx_ff;
  logic busy_ff;
  logic [15:0] crc_ff;

  // crc is folded as payload bytes go out and appended low byte first
  wire [15:0] crc_next = crc_byte(crc_ff, frame_ff[idx_ff[2:0]]); // [RULE16]
  wire send = busy_ff && link.req_ready;
  assign cmd_ready = !busy_ff;
  assign link.req_valid = busy_ff;
  assign link.req_data = (idx_ff == REQ_CRC_LO_POS) ? crc_ff[7:0] // checksum_low_byte [RULE5]
    : (idx_ff == REQ_CRC_HI_POS) ? crc_ff[15:8] : frame_ff[idx_ff[2:0]];
  // reply passes straight to the user, stall reaches the responder buffer
  assign rsp_byte = link.rsp_data;
  assign rsp_byte_valid = link.rsp_valid;
  assign link.rsp_ready = rsp_byte_ready;

  // request framing: address, function, start and count msb first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      idx_ff <= 4'h0;
      crc_ff <= CRC_INIT;
      for (int i = 0; i < REQ_LEN; i++) frame_ff[i] <= RESET_BYTE;
    end else if (!busy_ff) begin
      if (cmd_valid) begin
        frame_ff[0] <= cmd_addr; // [RULE1]
        frame_ff[1] <= cmd_func; // [RULE2] [RULE3]
        frame_ff[2] <= cmd_start[15:8]; // [RULE4]
        frame_ff[3] <= cmd_start[7:0];
        frame_ff[4] <= cmd_qty[15:8];
        frame_ff[5] <= cmd_qty[7:0];
        busy_ff <= 1'b1;
        idx_ff <= 4'h0;
        crc_ff <= CRC_INIT; // recomputed per request [RULE16]
      end
    end else if (send) begin
      if (idx_ff < REQ_CRC_LO_POS) crc_ff <= crc_next;
      idx_ff <= idx_ff + 4'h1;
      if (idx_ff == 4'(REQ_LEN - 1)) busy_ff <= 1'b0;
    end
  end
endmodule // modbus_coil_read_master
`default_nettype wire

// ==== bench/coil_link_monitor.sv ====
`default_nettype none
module coil_link_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // link signals
  input wire logic [7:0] req_data,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_ff;
  logic [3:0] idx_ff;
  logic [7:0] hdr_ff [8];
  wire logic take = req_valid && req_ready;
  wire logic last = take && cnt_ff == 3'h7;
  wire logic [15:0] qty = {hdr_ff[4], hdr_ff[5]};
  wire logic [3:0] last_idx = 4'(((qty + 16'h7) >> 3) + 16'h2);
  // request byte position and reply byte position
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 3'h0;
      idx_ff <= 4'h0;
    end else begin
      if (take) cnt_ff <= cnt_ff + 3'h1;
      if (last) idx_ff <= 4'h0;
      else if (rsp_valid && rsp_ready) idx_ff <= idx_ff + 4'h1;
    end
  end
  // request bytes kept for echo checks
  always_ff @(posedge sys_clk) begin
    if (take) hdr_ff[cnt_ff] <= req_data;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rsp_hold_a: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data)) else $error("reply byte moved");
  req_hold_a: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req_data)) else $error("request byte moved");
  check_gap_a: assert property (
    last |=> !req_ready) else $error("request taken after eighth byte");
  no_early_a: assert property (
    last |=> !rsp_valid) else $error("reply before check cycle");
  addr_echo_a: assert property (
    last |-> ##3 (!rsp_valid || rsp_data == hdr_ff[0])) else $error("address not echoed");
  func_echo_a: assert property (
    rsp_valid && idx_ff == 4'h1 |-> rsp_data == hdr_ff[1]) else $error("function not echoed");
  byte_count_a: assert property (
    rsp_valid && idx_ff == 4'h2 |-> rsp_data == 8'(last_idx - 4'h2)) else $error("bad count");
  unused_zero_a: assert property (
    rsp_valid && idx_ff == last_idx && qty[2:0] != 3'h0 |-> (rsp_data >> qty[2:0]) == 8'h0)
    else $error("unused bits set");
endmodule // coil_link_monitor
`default_nettype wire

// ==== bench/test_modbus_coil_read_responder.sv ====
`default_nettype none
module test_modbus_coil_read_responder;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic rsp_byte_ready = 1'b0;
  logic [7:0] own_addr = 8'h01, cmd_addr = 8'h00, cmd_func = 8'h00;
  logic [15:0] cmd_start = 16'h0, cmd_qty = 16'h0, input_states = 16'h0, output_states = 16'h0;
  logic cmd_ready, rsp_byte_valid, frame_dropped;
  logic [7:0] rsp_byte;
  logic [31:0] lfsr = 32'h367f;
  logic [7:0] got[$], sent[$];
  int exp_q[$], req_q[$];
  int fail_count = 0, cmp_count = 0, drops = 0, w;
  coil_link_if link ();
  modbus_coil_read_master modbus_coil_read_master_inst (.sys_clk, .reset_n, .link, .cmd_valid,
    .cmd_ready, .cmd_addr, .cmd_func, .cmd_start, .cmd_qty, .rsp_byte, .rsp_byte_valid,
    .rsp_byte_ready);
  modbus_coil_read_responder modbus_coil_read_responder_inst (.sys_clk, .reset_n, .link,
    .own_addr, .input_states, .output_states, .frame_dropped);
  coil_link_monitor coil_link_monitor_inst (.sys_clk, .reset_n, .req_data(link.req_data),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .rsp_data(link.rsp_data),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready));
  // clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic int crc_add(int c, int d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 'ha001) : (c >> 1);
    return c;
  endfunction
  // reference reply: empty when the frame must be dropped
  task automatic model(int a, int f, int s, int q, int own, int st);
    int c, v, n;
    exp_q = {};
    req_q = {a, f, s >> 8, s & 'hff, q >> 8, q & 'hff};
    c = 'hffff;
    foreach (req_q[k]) c = crc_add(c, req_q[k]);
    req_q.push_back(c & 'hff);
    req_q.push_back(c >> 8);
    if (a != own || own < 1 || own > 247 || (f != 1 && f != 2) || q < 1 || s + q > 16) return;
    n = (q + 7) / 8;
    v = (st >> s) & ((1 << q) - 1);
    exp_q = {a, f, n};
    for (int k = 0; k < n; k++) exp_q.push_back((v >> (8 * k)) & 'hff);
    c = 'hffff;
    foreach (exp_q[k]) c = crc_add(c, exp_q[k]);
    exp_q.push_back(c & 'hff);
    exp_q.push_back(c >> 8);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // receiver with random stalls; gathers reply bytes and drop pulses
  always @(posedge sys_clk) begin
    if (rsp_byte_valid === 1'b1 && rsp_byte_ready) got.push_back(rsp_byte);
    if (link.req_valid === 1'b1 && link.req_ready) sent.push_back(link.req_data);
    if (frame_dropped === 1'b1) drops++;
    lfsr <= step(lfsr);
    rsp_byte_ready <= lfsr[7] | lfsr[3];
  end
  // one request through the master, reply compared with the model
  task automatic run(int a, int f, int s, int q, int own, int ist, int ost);
    @(posedge sys_clk);
    own_addr <= 8'(own);
    cmd_addr <= 8'(a);
    cmd_func <= 8'(f);
    cmd_start <= 16'(s);
    cmd_qty <= 16'(q);
    input_states <= 16'(ist);
    output_states <= 16'(ost);
    cmd_valid <= 1'b1;
    model(a, f, s, q, own, f == 2 ? ist : ost);
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    got = {};
    sent = {};
    drops = 0;
    for (w = 0; w < 200 && (exp_q.size() ? got.size() < exp_q.size() : drops == 0); w++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk(got.size(), exp_q.size());
    chk(drops, exp_q.size() == 0);
    foreach (got[k]) chk(got[k], exp_q[k]);
    chk(sent.size(), coil_read_pkg::REQ_LEN);
    foreach (sent[k]) chk(sent[k], req_q[k]);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    run(1, 2, 0, 16, 1, 'h9003, 'h0);
    chk({sent[7], sent[6]}, 16'hc679);
    run(1, 1, 0, 16, 1, 'h0, 'hc305);
    chk({sent[7], sent[6]}, 16'hc63d);
    run(2, 2, 0, 16, 1, 'hffff, 'h0);
    run(0, 2, 0, 1, 0, 'hffff, 'h0);
    run(1, 3, 0, 8, 1, 'hffff, 'hffff);
    run(1, 2, 15, 1, 1, 'h8000, 'h0);
    run(1, 1, 3, 0, 1, 'h0, 'hffff);
    run(1, 2, 8, 9, 1, 'hffff, 'h0);
    run(1, 1, 'hffff, 1, 1, 'h0, 'hffff);
    for (int i = 0; i < 60; i++) begin
      run(lfsr[8] ? 1 + lfsr % 247 : 2 + lfsr % 247, 1 + lfsr[9], lfsr[13:10], lfsr[18:14] % 18,
        1 + lfsr % 247, lfsr[31:16], lfsr[23:8]);
    end
    tally_and_finish();
  end
endmodule // test_modbus_coil_read_responder
`default_nettype wire
